// ==== pkg/flash_host_defs.svh ====
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH
// ----------------------------------------
// Geometry and bus widths
// ----------------------------------------
`define FH_AW 21
`define FH_DW 16
`define FH_SEC_BITS 11
`define FH_BLK_BITS 15
`define FH_BIT_POLL 7
`define FH_BIT_TOGGLE 6
// ----------------------------------------
// Timing
// ----------------------------------------
`define FH_CLK_NS 40
`define FH_ACCESS_NS 70
`define FH_ACCESS_CYC ((`FH_ACCESS_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_PROG_US 10
`define FH_PROG_CYC (`FH_PROG_US * 1000 / `FH_CLK_NS)
`define FH_SUSP_US 10
`define FH_SUSP_CYC (`FH_SUSP_US * 1000 / `FH_CLK_NS)
`define FH_CNT_W 10
// ----------------------------------------
// Command codes and sequence lengths
// ----------------------------------------
`define FH_CODE_SECTOR 16'h0050
`define FH_CODE_BLOCK 16'h0030
`define FH_CODE_SUSPEND 16'h00B0
`define FH_CODE_RESUME 16'h0030
`define FH_N_PROG 3'h4
`define FH_N_ERASE 3'h6
`define FH_N_SINGLE 3'h1
`endif

// ==== pkg/flash_host_pkg.sv ====
`include "flash_host_defs.svh"
package flash_host_pkg;
  // ----------------------------------------
  // Operations, pins and states
  // ----------------------------------------
  typedef enum logic [2:0] {OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_SUSPEND, OP_RESUME} op_t;
  typedef struct packed {
    op_t op;
    logic [`FH_AW-1:0] addr;
    logic [`FH_DW-1:0] data;
  } cmd_t;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [`FH_AW-1:0] addr;
    logic [`FH_DW-1:0] dq;
    logic dq_oe;
  } pins_t;
  typedef struct packed {
    logic [`FH_AW-1:0] addr;
    logic [`FH_DW-1:0] data;
  } wcycle_t;
  typedef enum {ST_IDLE, ST_W_SETUP, ST_W_LOW, ST_W_HIGH, ST_W_GAP, ST_R_SETUP, ST_R_WAIT, ST_R_GAP, ST_S_WAIT} st_t;
endpackage

// ==== logic/flash_cmd_host.sv ====
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_cmd_host
  import flash_host_pkg::*;
#(
  parameter int READ_WAIT = `FH_ACCESS_CYC,
  parameter logic [`FH_AW-1:0] UNLOCK_ADDR1 = 21'h0_0000,
  parameter logic [`FH_AW-1:0] UNLOCK_ADDR2 = 21'h0_0001,
  parameter logic [`FH_DW-1:0] UNLOCK_DATA1 = 16'h0001,
  parameter logic [`FH_DW-1:0] UNLOCK_DATA2 = 16'h0002,
  parameter logic [`FH_DW-1:0] PROG_SETUP = 16'h0003,
  parameter logic [`FH_DW-1:0] ERASE_SETUP = 16'h0004,
  parameter logic [`FH_AW-1:0] PROT_BASE = 21'h0_0000
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_t cmd,
  output logic rsp_valid,
  output logic [`FH_DW-1:0] rsp_data,
  output logic rsp_err,
  output logic erase_suspended,
  input wire logic wp_level,
  output pins_t pins,
  output logic wp_n,
  input wire logic [`FH_DW-1:0] dq_in
);
  // ----------------------------------------
  // Parameter checks and helpers
  // ----------------------------------------
  if (READ_WAIT < 1 || READ_WAIT > 2 ** `FH_CNT_W - 1)
  begin : g_bad_wait
    $error("READ_WAIT out of range");
  end

  // Same sector or same block test
  function automatic logic in_region(input logic [`FH_AW-1:0] a, input logic [`FH_AW-1:0] b, input logic blk);
    in_region = blk ? (a[`FH_AW-1:`FH_BLK_BITS] == b[`FH_AW-1:`FH_BLK_BITS])
                    : (a[`FH_AW-1:`FH_SEC_BITS] == b[`FH_AW-1:`FH_SEC_BITS]);
  endfunction

  // Number of write cycles of an operation
  function automatic logic [2:0] n_writes(input op_t op);
    unique case (op)
      OP_PROGRAM: n_writes = `FH_N_PROG;
      OP_SECTOR_ERASE, OP_BLOCK_ERASE: n_writes = `FH_N_ERASE;
      default: n_writes = `FH_N_SINGLE;
    endcase
  endfunction

  // Address and data of write cycle i of a job
  function automatic wcycle_t seq_word(input logic [2:0] i, input cmd_t j);
    wcycle_t w;
    w.addr = j.addr;
    w.data = j.data;
    if (j.op == OP_SUSPEND)
      w.data = `FH_CODE_SUSPEND;
    else if (j.op == OP_RESUME)
      w.data = `FH_CODE_RESUME;
    else if (i == 3'h0 || (i == 3'h3 && j.op != OP_PROGRAM))
    begin
      w.addr = UNLOCK_ADDR1;
      w.data = UNLOCK_DATA1;
    end
    else if (i == 3'h1 || i == 3'h4)
    begin
      w.addr = UNLOCK_ADDR2;
      w.data = UNLOCK_DATA2;
    end
    else if (i == 3'h2)
    begin
      w.addr = UNLOCK_ADDR1;
      w.data = (j.op == OP_PROGRAM) ? PROG_SETUP : ERASE_SETUP;
    end
    else if (j.op == OP_SECTOR_ERASE)
      w.data = `FH_CODE_SECTOR;
    else if (j.op == OP_BLOCK_ERASE)
      w.data = `FH_CODE_BLOCK;
    return w;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  st_t st;
  cmd_t job;
  logic [2:0] idx;
  logic poll;
  logic have_prev;
  logic prev_tog;
  logic [`FH_CNT_W-1:0] cnt;
  logic [`FH_CNT_W-1:0] tmo;
  logic [`FH_DW-1:0] rd;
  logic er_active;
  logic er_block;
  logic [`FH_AW-1:0] er_addr;
  logic is_erase_job;
  logic poll_done;
  logic prog_tmo;
  logic take_susp;
  logic accept;
  logic bad;
  logic last_w;
  wcycle_t w_next;

  // Decode of the present step
  assign is_erase_job = job.op inside {OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_RESUME};
  assign poll_done = have_prev && (rd[`FH_BIT_TOGGLE] == prev_tog);
  assign prog_tmo = (job.op == OP_PROGRAM) && (tmo >= `FH_CNT_W'(`FH_PROG_CYC));
  assign take_susp = st == ST_R_GAP && poll && is_erase_job && !poll_done && cmd_valid && cmd.op == OP_SUSPEND;
  assign cmd_ready = (st == ST_IDLE) || take_susp;
  assign accept = cmd_valid && st == ST_IDLE;
  assign last_w = idx == n_writes(job.op) - 3'h1;
  assign w_next = seq_word(st == ST_IDLE ? 3'h0 : idx + 3'h1, st == ST_IDLE ? cmd : job);

  // Commands the flash would drop or that would hang the engine
  always_comb
  begin
    unique case (cmd.op)
      OP_READ: bad = 1'b0;
      OP_PROGRAM: bad = erase_suspended && in_region(cmd.addr, er_addr, er_block);
      OP_SECTOR_ERASE, OP_BLOCK_ERASE: bad = er_active || (!wp_level && in_region(cmd.addr, PROT_BASE, 1'b1));
      OP_RESUME: bad = !erase_suspended;
      default: bad = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Bus cycle sequencer and pins
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st <= ST_IDLE;
      job <= '0;
      idx <= 3'h0;
      poll <= 1'b0;
      cnt <= '0;
      rd <= '0;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
    end
    else
    begin
      unique case (st)
        ST_IDLE:
          if (accept && !bad)
          begin
            job <= cmd;
            idx <= 3'h0;
            // Select and gate low for a read
            if (cmd.op == OP_READ)
            begin
              poll <= 1'b0;
              st <= ST_R_SETUP;
              pins <= '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0, addr: cmd.addr, dq: '0, dq_oe: 1'b0};
            end
            else
            begin
              st <= ST_W_SETUP;
              pins <= '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b1, addr: w_next.addr, dq: w_next.data, dq_oe: 1'b1};
            end
          end
        ST_W_SETUP:
        begin
          pins.we_n <= 1'b0;
          st <= ST_W_LOW;
        end
        ST_W_LOW:
        begin
          pins.we_n <= 1'b1;
          st <= ST_W_HIGH;
        end
        ST_W_HIGH:
        begin
          pins.ce_n <= 1'b1;
          pins.dq_oe <= 1'b0;
          st <= ST_W_GAP;
        end
        ST_W_GAP:
          if (!last_w)
          begin
            idx <= idx + 3'h1;
            st <= ST_W_SETUP;
            pins <= '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b1, addr: w_next.addr, dq: w_next.data, dq_oe: 1'b1};
          end
          else if (job.op == OP_SUSPEND)
          begin
            cnt <= '0;
            st <= ST_S_WAIT;
          end
          else
          begin
            poll <= 1'b1;
            st <= ST_R_SETUP;
            pins <= '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0, addr: job.addr, dq: '0, dq_oe: 1'b0};
          end
        ST_R_SETUP:
        begin
          cnt <= '0;
          st <= ST_R_WAIT;
        end
        ST_R_WAIT:
          if (cnt == `FH_CNT_W'(READ_WAIT - 1))
          begin
            rd <= dq_in;
            pins.ce_n <= 1'b1;
            pins.oe_n <= 1'b1;
            st <= ST_R_GAP;
          end
          else
            cnt <= cnt + `FH_CNT_W'(1);
        ST_R_GAP:
          if (take_susp)
          begin
            // Suspend is the one command taken mid-erase
            job.op <= OP_SUSPEND;
            idx <= 3'h0;
            st <= ST_W_SETUP;
            pins <= '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b1, addr: job.addr, dq: `FH_CODE_SUSPEND, dq_oe: 1'b1};
          end
          else if (!poll || poll_done || prog_tmo)
            st <= ST_IDLE;
          else
          begin
            st <= ST_R_SETUP;
            pins <= '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0, addr: job.addr, dq: '0, dq_oe: 1'b0};
          end
        ST_S_WAIT:
          if (cnt == `FH_CNT_W'(`FH_SUSP_CYC - 1))
            st <= ST_IDLE;
          else
            cnt <= cnt + `FH_CNT_W'(1);
      endcase
    end
  end

  // ----------------------------------------
  // Status polling
  // ----------------------------------------
  // Two equal toggle reads end the wait
  always_ff @(posedge core_clk)
  begin
    if (rst || st == ST_IDLE)
    begin
      have_prev <= 1'b0;
      prev_tog <= 1'b0;
    end
    else if (st == ST_R_GAP && poll)
    begin
      have_prev <= 1'b1;
      prev_tog <= rd[`FH_BIT_TOGGLE];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || !poll || st == ST_IDLE)
      tmo <= '0;
    else if (!prog_tmo)
      tmo <= tmo + `FH_CNT_W'(1);
  end

  // ----------------------------------------
  // Erase bookkeeping and write protect
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      er_active <= 1'b0;
      er_block <= 1'b0;
      er_addr <= '0;
      erase_suspended <= 1'b0;
    end
    else if (st == ST_W_GAP && last_w && job.op inside {OP_SECTOR_ERASE, OP_BLOCK_ERASE})
    begin
      er_active <= 1'b1;
      er_block <= job.op == OP_BLOCK_ERASE;
      er_addr <= job.addr;
    end
    else if (st == ST_S_WAIT && cnt == `FH_CNT_W'(`FH_SUSP_CYC - 1))
      erase_suspended <= 1'b1;
    else if (st == ST_W_GAP && last_w && job.op == OP_RESUME)
      erase_suspended <= 1'b0;
    else if (st == ST_R_GAP && poll && is_erase_job && poll_done && !take_susp)
      er_active <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      wp_n <= 1'b1;
    else if (st == ST_IDLE)
      wp_n <= wp_level;
  end

  // ----------------------------------------
  // Response
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_err <= 1'b0;
    end
    else
    begin
      rsp_valid <= (accept && bad) || (st == ST_S_WAIT && cnt == `FH_CNT_W'(`FH_SUSP_CYC - 1))
                   || (st == ST_R_GAP && !take_susp && (!poll || poll_done || prog_tmo));
      rsp_err <= (accept && bad) || (st == ST_R_GAP && poll && !poll_done && prog_tmo);
      if (st == ST_R_GAP)
        rsp_data <= rd;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [2:0] we_cnt;
  always_ff @(posedge core_clk)
  begin
    if (rst || st == ST_IDLE)
      we_cnt <= 3'h0;
    else if (st == ST_W_LOW)
      we_cnt <= we_cnt + 3'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_WE_UNDER_CE: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n && pins.dq_oe)
    else $error("write strobe low without select");
  AST_DATA_HELD: assert property ($rose(pins.we_n) |-> $stable(pins.dq) && $stable(pins.addr) && !pins.ce_n)
    else $error("data or address moved at strobe rise");
  AST_PROG_FOUR: assert property ($rose(poll) && job.op == OP_PROGRAM |-> $past(we_cnt) == 3'h4)
    else $error("program not four write cycles");
  AST_ERASE_SIX: assert property ($rose(poll) && job.op inside {OP_SECTOR_ERASE, OP_BLOCK_ERASE}
    |-> $past(we_cnt) == 3'h6)
    else $error("erase not six write cycles");
  AST_BLOCK_CODE: assert property ($fell(pins.we_n) && job.op == OP_BLOCK_ERASE && idx == 3'h5
    |-> pins.dq == `FH_CODE_BLOCK ##1 pins.dq == `FH_CODE_BLOCK)
    else $error("block erase code wrong");
  AST_RESUME_ONE: assert property ($rose(poll) && job.op == OP_RESUME |-> $past(we_cnt) == 3'h1)
    else $error("resume not single cycle");
  AST_UNLOCK: assert property ($fell(pins.we_n) && idx == 3'h0 && job.op != OP_SUSPEND && job.op != OP_RESUME
    |-> pins.addr == UNLOCK_ADDR1 && pins.dq == UNLOCK_DATA1)
    else $error("first unlock cycle wrong");
  AST_PROG_WORD: assert property ($fell(pins.we_n) && job.op == OP_PROGRAM && idx == 3'h3
    |-> pins.addr == job.addr && pins.dq == job.data)
    else $error("program word cycle wrong");
  AST_WP_STEADY: assert property (st != ST_IDLE && $past(st) != ST_IDLE |-> $stable(wp_n))
    else $error("write protect moved in sequence");
  AST_PROG_BOUND: assert property ($rose(poll) && job.op == OP_PROGRAM |-> ##[1:300] rsp_valid)
    else $error("program wait unbounded");
  AST_NO_SUSP_PROG: assert property (st == ST_W_SETUP && job.op == OP_PROGRAM && erase_suspended
    |-> !in_region(job.addr, er_addr, er_block))
    else $error("program into suspended region");

  COV_PROGRAM: cover property ($rose(poll) && job.op == OP_PROGRAM ##[1:300] rsp_valid);
  COV_SUSPEND: cover property ($rose(erase_suspended));
  COV_RESUME: cover property (st == ST_W_GAP && job.op == OP_RESUME);
  COV_READ: cover property (st == ST_R_GAP && !poll);
endmodule

// ==== bench/flash_model.sv ====
`timescale 1ns/1ps
`include "flash_host_defs.svh"
// ----------------------------------------
// Flash device seen from its pins
// ----------------------------------------
module flash_model
  import flash_host_pkg::*;
#(
  parameter logic [`FH_DW-1:0] UNLOCK1 = 16'h0001,
  parameter logic [`FH_DW-1:0] PSETUP = 16'h0003,
  parameter logic [`FH_AW-1:0] PROT = 21'h0_0000,
  parameter int ERASE_NS = 40000
)(
  input wire pins_t pins,
  input wire logic wp_n,
  output logic [`FH_DW-1:0] dq_out
);
  localparam logic [`FH_AW-1:0] BMASK = {`FH_AW{1'b1}} << `FH_BLK_BITS;
  logic [`FH_DW-1:0] mem [logic [`FH_AW-1:0]];
  logic [`FH_AW-1:0] la, job, emask;
  logic [`FH_DW-1:0] d3, pval, rv = 16'h0000, last = 16'h0000;
  logic pbusy = 0, ebusy = 0, susp = 0, tgl = 0;
  int n_wr = 0, eleft, prog_ns = 7000;
  function automatic logic [`FH_DW-1:0] rd(input logic [`FH_AW-1:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  function automatic logic hit(input logic [`FH_AW-1:0] a);
    return ((a ^ job) & emask) == '0;
  endfunction
  task automatic prog(input logic [`FH_AW-1:0] a, input logic [`FH_DW-1:0] d);
    pbusy = 1;
    pval = d;
    #(prog_ns);
    mem[a] = rd(a) & d;
    pbusy = 0;
  endtask
  task automatic take(input logic [`FH_AW-1:0] a, input logic [`FH_DW-1:0] d);
    if (pbusy) return;
    if (ebusy)
    begin
      susp = (d == `FH_CODE_SUSPEND);
      ebusy = !susp;
      return;
    end
    if (susp && n_wr == 0 && d == `FH_CODE_RESUME)
    begin
      {susp, ebusy} = 2'h1;
      return;
    end
    if (n_wr == 0 && d != UNLOCK1) return;
    if (n_wr == 2) d3 = d;
    n_wr++;
    if (n_wr == 4 && d3 == PSETUP)
    begin
      n_wr = 0;
      if (!(susp && hit(a))) fork prog(a, d); join_none
    end
    if (n_wr < 6) return;
    n_wr = 0;
    if (wp_n == 1'b0 && (a & BMASK) == PROT) return;
    if (d != `FH_CODE_SECTOR && d != `FH_CODE_BLOCK) return;
    emask = {`FH_AW{1'b1}} << (d == `FH_CODE_SECTOR ? `FH_SEC_BITS : `FH_BLK_BITS);
    job = a;
    eleft = ERASE_NS;
    ebusy = 1;
  endtask
  always @(negedge pins.we_n) if (pins.ce_n === 1'b0) la = pins.addr;
  always @(posedge pins.we_n) if (pins.ce_n === 1'b0) take(la, pins.dq);
  // Erase progress, frozen while suspended
  always #40
    if (ebusy)
    begin
      eleft = eleft - 40;
      if (eleft <= 0)
      begin
        foreach (mem[k]) if (hit(k)) mem[k] = 16'hFFFF;
        ebusy = 0;
      end
    end
  always @(negedge pins.oe_n)
  begin
    #1;
    tgl = ~tgl;
    if (pbusy) rv = {8'h00, ~pval[7], tgl, 6'h00};
    else if (ebusy) rv = {8'h00, 1'h0, tgl, 3'h0, tgl, 2'h0};
    else if (susp && hit(pins.addr)) rv = {8'h00, 2'h3, 3'h0, tgl, 2'h0};
    else rv = rd(pins.addr);
  end
  // Released bus shows the inverse of the last word
  always @(posedge pins.oe_n) last = rv;
  assign dq_out = (pins.ce_n === 1'b0 && pins.oe_n === 1'b0) ? rv : ~last;
endmodule

// ==== bench/parallel_flash_command_engine_tb.sv ====
`timescale 1ns/1ps
`include "flash_host_defs.svh"
// ----------------------------------------
// Host engine against the flash model
// ----------------------------------------
module parallel_flash_command_engine_tb
  import flash_host_pkg::*;
();
  logic core_clk = 0, rst = 1, cmd_valid = 0, wp_level = 1;
  cmd_t cmd = '0;
  logic cmd_ready, rsp_valid, rsp_err, erase_suspended, wp_n, got_err;
  logic [`FH_DW-1:0] rsp_data, dq_in, flash_dq, got, d;
  logic [`FH_DW-1:0] shadow [logic [`FH_AW-1:0]];
  logic [`FH_AW-1:0] a;
  pins_t pins;
  int mismatches = 0, n_compared = 0, cyc = 0, seed = 94;
  always #20 core_clk = ~core_clk;
  // Shared data wire
  assign dq_in = (pins.dq_oe === 1'b1) ? pins.dq : flash_dq;
  flash_cmd_host u_flash_cmd_host (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .erase_suspended(erase_suspended),
    .wp_level(wp_level), .pins(pins), .wp_n(wp_n), .dq_in(dq_in));
  flash_model u_flash_model (.pins(pins), .wp_n(wp_n), .dq_out(flash_dq));
  task automatic chk16(input string what, input logic [`FH_DW-1:0] exp, input logic [`FH_DW-1:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic seen);
    chk16(what, {15'h0000, exp}, {15'h0000, seen});
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [`FH_DW-1:0] exp_rd(input logic [`FH_AW-1:0] x);
    return shadow.exists(x) ? shadow[x] : 16'hFFFF;
  endfunction
  function automatic void wipe(input logic [`FH_AW-1:0] x, input int bits);
    foreach (shadow[k]) if ((k >> bits) == (x >> bits)) shadow[k] = 16'hFFFF;
  endfunction
  // One command to its answer, optionally chased by a suspend
  task automatic run(input op_t op, input logic [`FH_AW-1:0] x, input logic [`FH_DW-1:0] v, input bit then_susp);
    cmd_valid <= 1'b1;
    cmd <= '{op, x, v};
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    if (then_susp) cmd.op <= OP_SUSPEND;
    else cmd_valid <= 1'b0;
    do
    begin
      @(posedge core_clk);
      if (cmd_valid && cmd_ready === 1'b1) cmd_valid <= 1'b0;
    end
    while (rsp_valid !== 1'b1);
    got = rsp_data;
    got_err = rsp_err;
  endtask
  task automatic look(input logic [`FH_AW-1:0] x);
    run(OP_READ, x, 16'h0000, 0);
    chk16("array word", exp_rd(x), got);
  endtask
  task automatic prog(input logic [`FH_AW-1:0] x, input logic [`FH_DW-1:0] v, input logic err);
    run(OP_PROGRAM, x, v, 0);
    chk1("program status", err, got_err);
    if (!err) shadow[x] = exp_rd(x) & v;
    if (!err) chk16("program final read", exp_rd(x), got);
  endtask
  task automatic erase(input op_t op, input logic [`FH_AW-1:0] x, input logic err, input bit s);
    run(op, x, 16'h0000, s);
    chk1("erase status", err, got_err);
    if (!err && !s) wipe(x, op == OP_SECTOR_ERASE ? `FH_SEC_BITS : `FH_BLK_BITS);
  endtask
  // Pin discipline and run limit on every rising clock edge
  always @(posedge core_clk)
  begin
    cyc++;
    if (!rst && pins.we_n === 1'b0) chk1("select during write", 1'b0, pins.ce_n);
    if (!rst && pins.oe_n === 1'b0) chk1("host drive in read", 1'b0, pins.dq_oe);
    if (cyc == 60000)
    begin
      mismatches++;
      end_sim();
    end
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk1("idle select", 1'b1, pins.ce_n);
    run(OP_SUSPEND, 21'h0_0000, 16'h0000, 0);
    chk1("suspend when idle", 1'b1, got_err);
    run(OP_RESUME, 21'h0_0000, 16'h0000, 0);
    chk1("resume when idle", 1'b1, got_err);
    for (int i = 0; i < 6; i++)
    begin
      a = 21'($random(seed)) | 21'h0_8000;
      d = 16'($random(seed));
      prog(a, d, 0);
      look(a);
      look(a ^ 21'h0_0001);
    end
    prog(21'h0_8FFF, 16'h1234, 0);
    prog(21'h0_9000, 16'h5678, 0);
    erase(OP_SECTOR_ERASE, 21'h0_8FFF, 0, 0);
    look(21'h0_8FFF);
    look(21'h0_9000);
    erase(OP_BLOCK_ERASE, 21'h0_8000, 0, 0);
    look(21'h0_9000);
    wp_level <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk1("protect pin", 1'b0, wp_n);
    erase(OP_BLOCK_ERASE, 21'h0_4000, 1, 0);
    erase(OP_SECTOR_ERASE, 21'h1_0000, 0, 0);
    wp_level <= 1'b1;
    prog(21'h1_0000, 16'h00F0, 0);
    prog(21'h1_0800, 16'hA5A5, 0);
    erase(OP_SECTOR_ERASE, 21'h1_0000, 0, 1);
    run(OP_READ, 21'h1_0000, 16'h0000, 0);
    chk1("suspended toggle bit", 1'b1, got[`FH_BIT_TOGGLE]);
    chk1("suspended flag", 1'b1, erase_suspended);
    look(21'h1_0800);
    prog(21'h1_0004, 16'h0000, 1);
    prog(21'h1_1000, 16'h3C3C, 0);
    look(21'h1_1000);
    erase(OP_BLOCK_ERASE, 21'h2_0000, 1, 0);
    run(OP_RESUME, 21'h1_F0F0, 16'h0000, 0);
    chk1("resume status", 1'b0, got_err);
    wipe(21'h1_0000, `FH_SEC_BITS);
    look(21'h1_0000);
    chk1("suspended flag", 1'b0, erase_suspended);
    look(21'h1_0800);
    u_flash_model.prog_ns = 12000;
    prog(21'h0_8000, 16'h0000, 1);
    u_flash_model.prog_ns = 7000;
    repeat (150) @(posedge core_clk);
    shadow[21'h0_8000] = 16'h0000;
    look(21'h0_8000);
    end_sim();
  end
endmodule
